// ===== bds_pkg.sv
// Shared constants and types for the bridge driver supervision ends
package bds_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_BASE_NS = 587;
  localparam int T_STEP_NS = 266;
  localparam int TF0_NS = 500;
  localparam int TF1_NS = 1000;
  localparam int TF2_NS = 2000;
  localparam int TF3_NS = 6000;
  localparam logic [10:0] TF0_CYC = 11'((TF0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] TF1_CYC = 11'((TF1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] TF2_CYC = 11'((TF2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [10:0] TF3_CYC = 11'((TF3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int T_CPUV_BLANK_NS = 10000;
  localparam logic [11:0] CPUV_BLANK_CYC =
    12'((T_CPUV_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Half-bridge modes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_HIZ = 2'h0;
  localparam logic [1:0] MODE_LS_ON = 2'h1;
  localparam logic [1:0] MODE_HS_ON = 2'h2;
  localparam logic [1:0] MODE_OFF_DIAG = 2'h3;
  localparam logic [2:0] VDS_TH_RST = 3'h1;
  localparam logic [2:0] VDS_TH_DIAG = 3'h7;
  localparam logic [1:0] TF_RST = 2'h0;
  localparam logic [3:0] CODE_RST = 4'h0;

  // ----------------------------------------------------------------
  // Controller register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VDS = 8'h04;
  localparam logic [7:0] REG_CCP0 = 8'h08;
  localparam logic [7:0] REG_CCP1 = 8'h0C;
  localparam logic [7:0] REG_CCP2 = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_CLR = 8'h18;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PWM_LSB = 6;
  localparam int CTRL_AFW_LSB = 9;
  localparam int CTRL_CHARGE_PUMP_ENABLE_BIT = 12;
  localparam int CTRL_FETLVL_BIT = 13;
  localparam int CTRL_PUMP_UV_THRESHOLD_SELECT_BIT = 14;
  localparam int CTRL_ICHG_LSB = 15;
  localparam int VDS_LS_LSB = 0;
  localparam int VDS_HS_LSB = 9;
  localparam int VDS_TF_LSB = 18;
  localparam int STAT_DRAIN_SOURCE_FAULT_STATUS_LSB = 0;
  localparam int STAT_GEN_BIT = 8;
  localparam int STAT_VOUT_LSB = 9;
  localparam int STAT_CPUV_BIT = 12;
  localparam int CLR_DRAIN_SOURCE_FAULT_STATUS_BIT = 0;
  localparam int CLR_SUP_BIT = 1;

  // ----------------------------------------------------------------
  // Types and lookup tables
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CPUV_RUN = 2'b00,
    CPUV_DISCH = 2'b01,
    CPUV_LATCH = 2'b10
  } bds_cpuv_type;

  function automatic logic [11:0] vds_th_mv(input logic [2:0] code);
    case (code)
      3'h0: vds_th_mv = 12'h0A0;
      3'h1: vds_th_mv = 12'h0C8;
      3'h2: vds_th_mv = 12'h12C;
      3'h3: vds_th_mv = 12'h190;
      3'h4: vds_th_mv = 12'h1F4;
      3'h5: vds_th_mv = 12'h258;
      3'h6: vds_th_mv = 12'h320;
      default: vds_th_mv = 12'h7D0;
    endcase
  endfunction

  function automatic logic [12:0] cpuv_th_mv(input logic [1:0] sel);
    case (sel)
      2'h0: cpuv_th_mv = 13'h1770;
      2'h1: cpuv_th_mv = 13'h1964;
      2'h2: cpuv_th_mv = 13'h1D4C;
      default: cpuv_th_mv = 13'h1F40;
    endcase
  endfunction

endpackage

// ===== bds_link_if.sv
// Link between the controller end and the supervised driver end
`timescale 1ns/10ps
`default_nettype none
interface bds_link_if;
  logic [2:0][1:0] half_bridge_mode;
  logic [2:0] half_bridge_pwm_enable;
  logic [2:0] active_freewheel_enable;
  logic charge_pump_enable;
  logic fet_level_select;
  logic pump_uv_threshold_select;
  logic [2:0] max_charge_current_control;
  logic [2:0][2:0] low_side_vds_threshold;
  logic [2:0][2:0] high_side_vds_threshold;
  logic [1:0] vds_filter_time;
  logic [2:0][3:0] cross_current_time_code_act;
  logic [2:0][3:0] cross_current_time_code_fw;
  logic [2:0][3:0] blank_time_code_act;
  logic [2:0][3:0] blank_time_code_fw;
  logic drain_source_fault_status_clear;
  logic sup_clear;
  logic [5:0] drain_source_fault_status;
  logic global_status_drain_source_fault_status;
  logic [2:0] half_bridge_output_level;
  logic pump_undervoltage_flag;

  modport dev (
    input half_bridge_mode, half_bridge_pwm_enable, active_freewheel_enable,
    input charge_pump_enable, fet_level_select, pump_uv_threshold_select,
    input max_charge_current_control, low_side_vds_threshold,
    input high_side_vds_threshold, vds_filter_time,
    input cross_current_time_code_act, cross_current_time_code_fw,
    input blank_time_code_act, blank_time_code_fw, drain_source_fault_status_clear, sup_clear,
    output drain_source_fault_status, global_status_drain_source_fault_status,
    output half_bridge_output_level, pump_undervoltage_flag
  );

  modport ctl (
    output half_bridge_mode, half_bridge_pwm_enable, active_freewheel_enable,
    output charge_pump_enable, fet_level_select, pump_uv_threshold_select,
    output max_charge_current_control, low_side_vds_threshold,
    output high_side_vds_threshold, vds_filter_time,
    output cross_current_time_code_act, cross_current_time_code_fw,
    output blank_time_code_act, blank_time_code_fw, drain_source_fault_status_clear, sup_clear,
    input drain_source_fault_status, global_status_drain_source_fault_status,
    input half_bridge_output_level, pump_undervoltage_flag
  );
endinterface
`default_nettype wire

// ===== bds_driver.sv
// Supervised three half-bridge gate driver end
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module bds_driver (
  input wire logic clk_i, // 200 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  bds_link_if.dev link, // Controller link
  input wire logic [2:0] pwm_i, // PWM input per bridge
  input wire logic [2:0] vds_hs_over_i, // High-side VDS comparator
  input wire logic [2:0] vds_ls_over_i, // Low-side VDS comparator
  input wire logic [2:0] vsh_high_i, // Switch-node level
  input wire logic vcp_low_i, // Pump output below threshold
  input wire logic supply_ok_i, // Supplies within range
  output logic [2:0] gate_hs_o, // High-side gate on
  output logic [2:0] gate_ls_o, // Low-side gate on
  output logic [2:0] dis_hs_o, // High-side static discharge
  output logic [2:0] dis_ls_o, // Low-side static discharge
  output logic [2:0] pull_up_o, // Diagnostic pull-up current
  output logic [2:0] pull_down_o, // Diagnostic pull-down current
  output logic [2:0][11:0] ls_th_mv_o, // Low-side threshold, mV
  output logic [2:0][11:0] hs_th_mv_o, // High-side threshold, mV
  output logic [12:0] cpuv_th_mv_o, // Pump UV threshold, mV
  output logic cp_on_o, // Charge pump running
  output logic csa_on_o // Current sense amplifier on
);

  // ----------------------------------------------------------------
  // Shared state
  // ----------------------------------------------------------------
  bds_pkg::bds_cpuv_type cpuv_q;
  logic [5:0] drain_source_fault_status_q;
  logic [5:0] hit;
  logic [2:0] busy;
  logic gsum_q;
  logic [2:0] vout_q;
  logic [2:0] pu_q;
  logic [2:0] pd_q;
  logic [2:0][11:0] ls_th_q;
  logic [2:0][11:0] hs_th_q;
  logic [12:0] cpuv_th_q;
  logic cp_on_q;
  logic csa_q;
  logic [11:0] cpb_q;
  logic drv_en;
  logic [10:0] filt_cyc;

  assign drv_en = supply_ok_i & link.charge_pump_enable
                  & (cpuv_q == bds_pkg::CPUV_RUN);

  function automatic logic [10:0] code_cyc(input logic [3:0] code);
    logic [12:0] ns;
    ns = 13'(bds_pkg::T_BASE_NS) + 13'(bds_pkg::T_STEP_NS) * 13'(code);
    code_cyc = 11'((ns + 13'(bds_pkg::CLK_PERIOD_NS - 1))
                   / 13'(bds_pkg::CLK_PERIOD_NS));
  endfunction

  always_comb begin
    case (link.vds_filter_time)
      2'h0: filt_cyc = bds_pkg::TF0_CYC;
      2'h1: filt_cyc = bds_pkg::TF1_CYC;
      2'h2: filt_cyc = bds_pkg::TF2_CYC;
      default: filt_cyc = bds_pkg::TF3_CYC;
    endcase
  end

  // ----------------------------------------------------------------
  // Per half-bridge sequencing
  // ----------------------------------------------------------------
  for (genvar b = 0; b < 3; b++) begin : g_hb
    logic [1:0] want;
    logic want_act;
    logic [1:0] on_q;
    logic [1:0] dis_q;
    logic [10:0] tmr_q;
    logic [10:0] blk_q;
    logic [10:0] flt_q;
    logic mon;
    logic trip;
    logic [10:0] ccp_cyc;
    logic [10:0] blk_cyc;
    logic [1:0] act_fet;

    // Bit 1 is high side, bit 0 low side
    always_comb begin
      act_fet = (link.half_bridge_mode[b] == bds_pkg::MODE_HS_ON) ? 2'h2 :
                (link.half_bridge_mode[b] == bds_pkg::MODE_LS_ON) ? 2'h1 :
                2'h0;
      want = 2'h0;
      want_act = 1'b1;
      if (link.half_bridge_pwm_enable[b]) begin
        if (pwm_i[b]) begin
          want = act_fet;
        end else if (link.active_freewheel_enable[b]) begin
          want = {act_fet[0], act_fet[1]};
          want_act = 1'b0;
        end
      end else begin
        want = act_fet;
      end
      if (!drv_en || drain_source_fault_status_q[b] || drain_source_fault_status_q[3+b]) begin
        want = 2'h0;
        want_act = 1'b1;
      end
      ccp_cyc = code_cyc(want_act ? link.cross_current_time_code_act[b]
                                  : link.cross_current_time_code_fw[b]);
      // Blank length per active or freewheel FET
      blk_cyc = code_cyc(want_act ? link.blank_time_code_act[b]
                                  : link.blank_time_code_fw[b]);
    end

    // Monitor only after blank, during on state
    assign mon = (tmr_q == 11'h000) && (blk_q == 11'h000)
                 && ((on_q[1] && vds_hs_over_i[b])
                     || (on_q[0] && vds_ls_over_i[b]));
    assign trip = mon && (flt_q >= filt_cyc);
    assign hit[3+b] = trip & on_q[0];
    assign hit[b] = trip & on_q[1];
    assign busy[b] = (on_q != 2'h0) || (tmr_q != 11'h000);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        flt_q <= 11'h000;
      end else if (!mon) begin
        flt_q <= 11'h000;
      end else if (flt_q != 11'h7FF) begin
        flt_q <= flt_q + 11'h001;
      end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        on_q <= 2'h0;
        dis_q <= 2'h0;
        tmr_q <= 11'h000;
        blk_q <= 11'h000;
      end else if (tmr_q != 11'h000) begin
        tmr_q <= tmr_q - 11'h001;
        if (tmr_q == 11'h001) begin
          dis_q <= 2'h0;
          // Blank starts as cross-current time ends
          if (want != 2'h0) begin
            on_q <= want;
            blk_q <= blk_cyc;
          end
        end
      end else if (trip) begin
        on_q <= 2'h0;
        dis_q <= on_q;
        tmr_q <= code_cyc(link.cross_current_time_code_act[b]);
      end else if (want != on_q) begin
        if (on_q != 2'h0) begin
          on_q <= 2'h0;
          dis_q <= on_q;
          tmr_q <= ccp_cyc;
        end else begin
          // From high impedance, blank starts now
          on_q <= want;
          blk_q <= blk_cyc;
        end
      end else if (blk_q != 11'h000) begin
        blk_q <= blk_q - 11'h001;
      end
    end

    assign gate_hs_o[b] = on_q[1];
    assign gate_ls_o[b] = on_q[0];
    assign dis_hs_o[b] = dis_q[1];
    assign dis_ls_o[b] = dis_q[0];
  end

  // ----------------------------------------------------------------
  // Status and diagnostics
  // ----------------------------------------------------------------
  // Per-FET and summary bits, set wins over clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drain_source_fault_status_q <= 6'h00;
      gsum_q <= 1'b0;
    end else begin
      drain_source_fault_status_q <= (link.drain_source_fault_status_clear ? 6'h00 : drain_source_fault_status_q) | hit;
      gsum_q <= |((link.drain_source_fault_status_clear ? 6'h00 : drain_source_fault_status_q) | hit);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vout_q <= 3'h0;
      pu_q <= 3'h0;
      pd_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        // Readback only in mode 11 with pump enabled
        vout_q[i] <= vsh_high_i[i] & link.charge_pump_enable
                     & (link.half_bridge_mode[i] == bds_pkg::MODE_OFF_DIAG);
        pu_q[i] <= link.charge_pump_enable
                   & (link.half_bridge_mode[i] != bds_pkg::MODE_HIZ);
        pd_q[i] <= link.max_charge_current_control[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ls_th_q <= {3{12'h0C8}};
      hs_th_q <= {3{12'h0C8}};
      cpuv_th_q <= 13'h1770;
    end else begin
      for (int i = 0; i < 3; i++) begin
        ls_th_q[i] <= bds_pkg::vds_th_mv(link.low_side_vds_threshold[i]);
        hs_th_q[i] <= bds_pkg::vds_th_mv(link.high_side_vds_threshold[i]);
      end
      cpuv_th_q <= bds_pkg::cpuv_th_mv({link.fet_level_select,
                                        link.pump_uv_threshold_select});
    end
  end

  // ----------------------------------------------------------------
  // Charge pump undervoltage
  // ----------------------------------------------------------------
  // Blank reloads at each pump activation
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cp_on_q <= 1'b0;
      csa_q <= 1'b0;
      cpb_q <= 12'h000;
    end else begin
      cp_on_q <= link.charge_pump_enable & (cpuv_q != bds_pkg::CPUV_LATCH);
      csa_q <= link.charge_pump_enable & (cpuv_q != bds_pkg::CPUV_LATCH);
      if (!cp_on_q) begin
        cpb_q <= bds_pkg::CPUV_BLANK_CYC;
      end else if (cpb_q != 12'h000) begin
        cpb_q <= cpb_q - 12'h001;
      end
    end
  end

  // Discharge via each bridge's timer, then latch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpuv_q <= bds_pkg::CPUV_RUN;
    end else begin
      unique case (cpuv_q)
        bds_pkg::CPUV_RUN: begin
          if (link.charge_pump_enable && cp_on_q && cpb_q == 12'h000
              && vcp_low_i) begin
            cpuv_q <= (|busy) ? bds_pkg::CPUV_DISCH : bds_pkg::CPUV_LATCH;
          end
        end
        bds_pkg::CPUV_DISCH: begin
          if (!(|busy)) begin
            cpuv_q <= bds_pkg::CPUV_LATCH;
          end
        end
        bds_pkg::CPUV_LATCH: begin
          // Clear needs status clear and good pump
          if (link.sup_clear && !vcp_low_i) begin
            cpuv_q <= bds_pkg::CPUV_RUN;
          end
        end
        default: cpuv_q <= bds_pkg::CPUV_RUN;
      endcase
    end
  end

  assign link.drain_source_fault_status = drain_source_fault_status_q;
  assign link.global_status_drain_source_fault_status = gsum_q;
  assign link.half_bridge_output_level = vout_q;
  assign link.pump_undervoltage_flag = (cpuv_q == bds_pkg::CPUV_LATCH);
  assign pull_up_o = pu_q;
  assign pull_down_o = pd_q;
  assign ls_th_mv_o = ls_th_q;
  assign hs_th_mv_o = hs_th_q;
  assign cpuv_th_mv_o = cpuv_th_q;
  assign cp_on_o = cp_on_q;
  assign csa_on_o = csa_q;

endmodule
`default_nettype wire

// ===== bds_ctrl.sv
// Controller end: software register file driving the link
`timescale 1ns/10ps
`default_nettype none
module bds_ctrl (
  input wire logic clk_i, // 200 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [7:0] addr_i, // Register byte address
  input wire logic [31:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [31:0] rdata_o, // Read data, cycle after rd_i
  bds_link_if.ctl link // Link to driver end
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [19:0] vds_q;
  logic [2:0][15:0] ccp_q;
  logic [1:0] clr_q;
  logic [31:0] rdata_q;
  logic [31:0] stat;
  logic [31:0] rmux;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= 32'h0000_0000;
    end else if (wr_i && addr_i == bds_pkg::REG_CTRL) begin
      ctrl_q <= {14'h0000, wdata_i[17:0]};
    end
  end

  // Threshold only updated in modes 00 or 11
  // Code 7 selects 2 V for off-state diagnosis
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vds_q <= {bds_pkg::TF_RST, {6{bds_pkg::VDS_TH_RST}}};
    end else if (wr_i && addr_i == bds_pkg::REG_VDS) begin
      vds_q[19:18] <= wdata_i[19:18];
      for (int i = 0; i < 3; i++) begin
        if (ctrl_q[2*i +: 2] == bds_pkg::MODE_HIZ
            || ctrl_q[2*i +: 2] == bds_pkg::MODE_OFF_DIAG) begin
          vds_q[bds_pkg::VDS_LS_LSB + 3*i +: 3] <=
            wdata_i[bds_pkg::VDS_LS_LSB + 3*i +: 3];
          vds_q[bds_pkg::VDS_HS_LSB + 3*i +: 3] <=
            wdata_i[bds_pkg::VDS_HS_LSB + 3*i +: 3];
        end
      end
    end
  end

  // Timing writes ignored while any PWM enable set
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ccp_q <= {12{bds_pkg::CODE_RST}};
    end else if (wr_i && ctrl_q[bds_pkg::CTRL_PWM_LSB +: 3] == 3'h0) begin
      if (addr_i == bds_pkg::REG_CCP0) ccp_q[0] <= wdata_i[15:0];
      if (addr_i == bds_pkg::REG_CCP1) ccp_q[1] <= wdata_i[15:0];
      if (addr_i == bds_pkg::REG_CCP2) ccp_q[2] <= wdata_i[15:0];
    end
  end

  // Clear strobes to re-enable faulted bridges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_q <= 2'h0;
    end else if (wr_i && addr_i == bds_pkg::REG_CLR) begin
      clr_q <= {wdata_i[bds_pkg::CLR_SUP_BIT], wdata_i[bds_pkg::CLR_DRAIN_SOURCE_FAULT_STATUS_BIT]};
    end else begin
      clr_q <= 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    stat = 32'h0000_0000;
    stat[bds_pkg::STAT_DRAIN_SOURCE_FAULT_STATUS_LSB +: 6] = link.drain_source_fault_status;
    stat[bds_pkg::STAT_GEN_BIT] = link.global_status_drain_source_fault_status;
    stat[bds_pkg::STAT_VOUT_LSB +: 3] = link.half_bridge_output_level;
    stat[bds_pkg::STAT_CPUV_BIT] = link.pump_undervoltage_flag;
    case (addr_i)
      bds_pkg::REG_CTRL: rmux = ctrl_q;
      bds_pkg::REG_VDS: rmux = {12'h000, vds_q};
      bds_pkg::REG_CCP0: rmux = {16'h0000, ccp_q[0]};
      bds_pkg::REG_CCP1: rmux = {16'h0000, ccp_q[1]};
      bds_pkg::REG_CCP2: rmux = {16'h0000, ccp_q[2]};
      bds_pkg::REG_STAT: rmux = stat;
      default: rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_q <= rmux;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Link drive
  // ----------------------------------------------------------------
  for (genvar b = 0; b < 3; b++) begin : g_link
    assign link.half_bridge_mode[b] = ctrl_q[2*b +: 2];
    assign link.low_side_vds_threshold[b] =
      vds_q[bds_pkg::VDS_LS_LSB + 3*b +: 3];
    assign link.high_side_vds_threshold[b] =
      vds_q[bds_pkg::VDS_HS_LSB + 3*b +: 3];
    assign link.cross_current_time_code_act[b] = ccp_q[b][3:0];
    assign link.cross_current_time_code_fw[b] = ccp_q[b][7:4];
    assign link.blank_time_code_act[b] = ccp_q[b][11:8];
    assign link.blank_time_code_fw[b] = ccp_q[b][15:12];
  end

  assign link.half_bridge_pwm_enable = ctrl_q[bds_pkg::CTRL_PWM_LSB +: 3];
  assign link.active_freewheel_enable = ctrl_q[bds_pkg::CTRL_AFW_LSB +: 3];
  assign link.charge_pump_enable = ctrl_q[bds_pkg::CTRL_CHARGE_PUMP_ENABLE_BIT];
  assign link.fet_level_select = ctrl_q[bds_pkg::CTRL_FETLVL_BIT];
  assign link.pump_uv_threshold_select = ctrl_q[bds_pkg::CTRL_PUMP_UV_THRESHOLD_SELECT_BIT];
  assign link.max_charge_current_control = ctrl_q[bds_pkg::CTRL_ICHG_LSB +: 3];
  assign link.vds_filter_time = vds_q[bds_pkg::VDS_TF_LSB +: 2];
  assign link.drain_source_fault_status_clear = clr_q[0];
  assign link.sup_clear = clr_q[1];
  assign rdata_o = rdata_q;

endmodule
`default_nettype wire

// ===== bds_link_asserts.sv
// Assertions on the link between the two ends
`timescale 1ns/10ps
`default_nettype none
module bds_link_asserts (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [2:0][1:0] half_bridge_mode, // Bridge modes
  input wire logic [2:0] half_bridge_pwm_enable, // PWM enables
  input wire logic charge_pump_enable, // Pump enable
  input wire logic [2:0][2:0] low_side_vds_threshold, // LS codes
  input wire logic [2:0][3:0] cross_current_time_code_act, // CCP codes
  input wire logic drain_source_fault_status_clear, // Fault clear pulse
  input wire logic sup_clear, // Supply clear pulse
  input wire logic [5:0] drain_source_fault_status, // Fault bits
  input wire logic global_status_drain_source_fault_status, // Summary bit
  input wire logic [2:0] half_bridge_output_level, // Readback
  input wire logic pump_undervoltage_flag // Pump UV flag
);
  // ----
  // Helpers
  // ----
  logic [2:0] rd_ok;
  for (genvar b = 0; b < 3; b++) begin
    assign rd_ok[b] = charge_pump_enable && half_bridge_mode[b] == 2'h3;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----
  // Properties
  // ----
  property p_glob;
    $rose(|drain_source_fault_status) |-> global_status_drain_source_fault_status;
  endproperty
  a_glob: assert property (p_glob) else $error("summary bit missing");
  property p_hold;
    !drain_source_fault_status_clear |=> (drain_source_fault_status &
      $past(drain_source_fault_status)) == $past(drain_source_fault_status);
  endproperty
  a_hold: assert property (p_hold) else $error("fault bit lost");
  property p_vout;
    (half_bridge_output_level & ~$past(rd_ok)) == 3'h0;
  endproperty
  a_vout: assert property (p_vout) else $error("readback not zero");
  property p_uv_hold;
    pump_undervoltage_flag && !sup_clear |=> pump_undervoltage_flag;
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("uv flag lost");
  property p_uv_rel;
    $fell(pump_undervoltage_flag) |-> $past(sup_clear);
  endproperty
  a_uv_rel: assert property (p_uv_rel) else $error("uv flag fell");
  property p_uv_charge_pump_enable;
    $rose(pump_undervoltage_flag) |-> charge_pump_enable;
  endproperty
  a_uv_charge_pump_enable: assert property (p_uv_charge_pump_enable) else $error("uv no pump");
  property p_ccp;
    |$past(half_bridge_pwm_enable) |-> $stable(cross_current_time_code_act);
  endproperty
  a_ccp: assert property (p_ccp) else $error("ccp changed");
  property p_th;
    $past(half_bridge_mode[0][0] ^ half_bridge_mode[0][1]) |->
      $stable(low_side_vds_threshold[0]);
  endproperty
  a_th: assert property (p_th) else $error("threshold changed");
  c_fault: cover property ($rose(global_status_drain_source_fault_status));
  c_uv: cover property ($rose(pump_undervoltage_flag));
  c_uv_clr: cover property ($fell(pump_undervoltage_flag));
endmodule
`default_nettype wire

// ===== bds_tb_top.sv
// Testbench joining the controller and driver ends
`timescale 1ns/10ps
`default_nettype none
module bds_tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic we = 1'b0, re = 1'b0, vcpl = 1'b0, sok = 1'b1, current_sense_amplifier;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [2:0] pwm = 3'h0, lso = 3'h0, vsh = 3'h0, ghs, gls, pu, pd;
  logic [2:0] hso = 3'h0, dhs, dls;
  logic [2:0][11:0] lsmv, hsmv;
  logic cpo;
  logic [12:0] cth;
  int fails = 0, n_checks = 0;
  logic [11:0] th_mv [8] = '{12'h0A0, 12'h0C8, 12'h12C, 12'h190, 12'h1F4,
    12'h258, 12'h320, 12'h7D0};
  always #2.5 clk_i = ~clk_i;
  bds_link_if link();
  bds_ctrl bds_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wdata_i(wd), .wr_i(we), .rd_i(re), .rdata_o(rdata), .link(link));
  bds_driver bds_driver_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
    .pwm_i(pwm), .vds_hs_over_i(hso), .vds_ls_over_i(lso), .vsh_high_i(vsh),
    .vcp_low_i(vcpl), .supply_ok_i(sok), .gate_hs_o(ghs), .gate_ls_o(gls),
    .dis_hs_o(dhs), .dis_ls_o(dls), .pull_up_o(pu), .pull_down_o(pd),
    .ls_th_mv_o(lsmv), .hs_th_mv_o(hsmv), .cpuv_th_mv_o(cth), .cp_on_o(cpo),
    .csa_on_o(current_sense_amplifier));
  bds_link_asserts bds_link_asserts_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .half_bridge_mode(link.half_bridge_mode),
    .half_bridge_pwm_enable(link.half_bridge_pwm_enable),
    .charge_pump_enable(link.charge_pump_enable),
    .low_side_vds_threshold(link.low_side_vds_threshold),
    .cross_current_time_code_act(link.cross_current_time_code_act),
    .drain_source_fault_status_clear(link.drain_source_fault_status_clear), .sup_clear(link.sup_clear),
    .drain_source_fault_status(link.drain_source_fault_status),
    .global_status_drain_source_fault_status(link.global_status_drain_source_fault_status),
    .half_bridge_output_level(link.half_bridge_output_level),
    .pump_undervoltage_flag(link.pump_undervoltage_flag));
  // ----
  // Bus and check tasks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_ds;
    wreg(8'h00, 32'h1001);
    repeat (200) @(posedge clk_i);
    wreg(8'h04, 32'h40000);
    rreg(8'h04, 32'hC0007, 32'h40007);
    lso <= 3'h1;
    repeat (195) @(posedge clk_i);
    #1 chk(gls, 3'h1);
    repeat (15) @(posedge clk_i);
    #1 chk({gls, dls}, 6'h01);
    rreg(8'h14, 32'h1FF, 32'h108);
    lso <= 3'h0;
    repeat (300) @(posedge clk_i);
    #1 chk(gls, 3'h0);
    wreg(8'h18, 32'h1);
    repeat (300) @(posedge clk_i);
    #1 chk(gls, 3'h1);
    sok <= 1'b0;
    repeat (130) @(posedge clk_i);
    #1 chk(gls, 3'h0);
    // Recovery must blank: unblanked trip would come 118 cycles early
    sok <= 1'b1;
    lso <= 3'h1;
    repeat (250) @(posedge clk_i);
    #1 chk(gls, 3'h1);
    lso <= 3'h0;
  endtask
  task automatic t_pwm;
    wreg(8'h00, 32'h1241);
    wreg(8'h08, 32'hFFFF);
    rreg(8'h08, 32'hFFFF, 32'h0);
    pwm <= 3'h1;
    repeat (300) @(posedge clk_i);
    #1 chk(gls, 3'h1);
    pwm <= 3'h0;
    repeat (118) @(posedge clk_i);
    #1 chk(ghs, 3'h0);
    @(posedge clk_i);
    #1 chk(ghs, 3'h1);
    hso <= 3'h1;
    repeat (330) @(posedge clk_i);
    #1 chk({ghs, dhs}, 6'h01);
    rreg(8'h14, 32'h1FF, 32'h101);
    hso <= 3'h0;
    wreg(8'h18, 32'h1);
  endtask
  task automatic t_diag;
    wreg(8'h00, 32'h9003);
    vsh <= 3'h7;
    repeat (5) @(posedge clk_i);
    #1 chk({pu, pd}, 6'h09);
    rreg(8'h14, 32'hE00, 32'h200);
    wreg(8'h00, 32'h8003);
    repeat (3) @(posedge clk_i);
    rreg(8'h14, 32'hE00, 32'h0);
    chk(pu, 3'h0);
  endtask
  task automatic t_uv;
    wreg(8'h00, 32'h7001);
    repeat (2100) @(posedge clk_i);
    #1 chk(gls, 3'h1);
    chk(cth, 13'h1F40);
    vcpl <= 1'b1;
    repeat (400) @(posedge clk_i);
    #1 chk({gls, cpo, current_sense_amplifier}, 5'h0);
    rreg(8'h14, 32'h1000, 32'h1000);
    wreg(8'h18, 32'h2);
    rreg(8'h14, 32'h1000, 32'h1000);
    vcpl <= 1'b0;
    wreg(8'h18, 32'h2);
    repeat (3) @(posedge clk_i);
    rreg(8'h14, 32'h1000, 32'h0);
  endtask
  always @(negedge clk_i) if (rst_n_i && (ghs & gls) !== 3'h0) chk(ghs, 0);
  initial begin
    #200us;
    fails++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1 chk({lsmv[0], hsmv[0]}, {2{12'h0C8}});
    for (int i = 0; i < 8; i++) begin
      wreg(8'h04, 32'(i));
      repeat (2) @(posedge clk_i);
      #1 chk(lsmv[0], th_mv[i]);
    end
    t_ds();
    t_pwm();
    t_diag();
    t_uv();
    summarize();
  end
endmodule
`default_nettype wire
